// ---- pfc_pwm.sv ----
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module pfc_pwm #(
   parameter int unsigned COUNT_W = 16
) (
   input  wire logic                          CORE_CLK_I,
   input  wire logic                          ARST_N_I,
   input  wire logic [pfc_pwm_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
   input  wire logic                          S_AXI_AWVALID_I,
   output var  logic                          S_AXI_AWREADY_O,
   input  wire logic [31:0]                   S_AXI_WDATA_I,
   input  wire logic [3:0]                    S_AXI_WSTRB_I,
   input  wire logic                          S_AXI_WVALID_I,
   output var  logic                          S_AXI_WREADY_O,
   output var  logic [1:0]                    S_AXI_BRESP_O,
   output var  logic                          S_AXI_BVALID_O,
   input  wire logic                          S_AXI_BREADY_I,
   input  wire logic [pfc_pwm_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
   input  wire logic                          S_AXI_ARVALID_I,
   output var  logic                          S_AXI_ARREADY_O,
   output var  logic [31:0]                   S_AXI_RDATA_O,
   output var  logic [1:0]                    S_AXI_RRESP_O,
   output var  logic                          S_AXI_RVALID_O,
   input  wire logic                          S_AXI_RREADY_I,
   output var  logic                          WAVE_A_PIN_O,
   output var  logic                          WAVE_A_OE_O,
   output var  logic                          WAVE_B_PIN_O,
   output var  logic                          WAVE_B_OE_O
);
   import pfc_pwm_pkg::*;
   if (COUNT_W < 2 || COUNT_W > 32) begin : g_bad_width
      $error("COUNT_W must lie between 2 and 32");
   end
   localparam logic [COUNT_W-1:0] BOTTOM = '0;
   localparam logic [COUNT_W-1:0] ONE    = {{(COUNT_W-1){1'b0}}, 1'b1};
   // Bus handshake state
   logic                awready, next_awready, wready, next_wready;
   logic                aw_held, next_aw_held, w_held, next_w_held;
   logic [ADDR_W-1:0]   wr_addr, next_wr_addr;
   logic [31:0]         wr_data, next_wr_data;
   logic [3:0]          wr_strb, next_wr_strb;
   logic                bvalid, next_bvalid, arready, next_arready, rvalid, next_rvalid;
   logic [1:0]          bresp, next_bresp, rresp, next_rresp;
   logic [31:0]         rdata, next_rdata;
   logic                wr_fire;
   // Timer state
   logic [31:0]         ctrl, next_ctrl;
   logic [COUNT_W-1:0]  cap_top, next_cap_top;
   logic [COUNT_W-1:0]  cmp_a_buf, next_cmp_a_buf, cmp_b_buf, next_cmp_b_buf;
   logic [COUNT_W-1:0]  cmp_a, next_cmp_a, cmp_b, next_cmp_b;
   logic [COUNT_W-1:0]  cnt, next_cnt;
   logic                count_down, next_count_down;
   logic [FLAG_W-1:0]   flags, next_flags;
   logic                wave_a, next_wave_a, wave_b, next_wave_b;
   logic                pin_a, next_pin_a, pin_b, next_pin_b, oe_a, next_oe_a, oe_b, next_oe_b;
   logic [9:0]          presc, next_presc;
   logic [3:0]          waveform_select;
   logic [1:0]          output_action_a, output_action_b;
   logic [2:0]          clock_select;
   logic                timer_tick, pfc_mode, at_bottom, at_top_turn, counting_up;
   logic [COUNT_W-1:0]  top_val;
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = data[8*i +: 8];
         end
      end
      return res;
   endfunction
   function automatic logic valid_addr(input logic [ADDR_W-1:0] a);
      return (a == CTRL_OFS) || (a == CAP_TOP_OFS) || (a == CMP_A_OFS) || (a == CMP_B_OFS) ||
             (a == COUNT_OFS) || (a == FLAGS_OFS);
   endfunction
   function automatic logic pwm_level(input logic [1:0] act, input logic up, input logic cur,
                                      input logic may_toggle);
      unique case (act)
         ACT_NONINV: return !up;
         ACT_INV:    return up;
         ACT_TOGGLE: return may_toggle ? !cur : cur;
         default:    return cur;
      endcase
   endfunction
   assign waveform_select = ctrl[WS_LSB +: 4];
   assign output_action_a = ctrl[ACT_A_LSB +: 2];
   assign output_action_b = ctrl[ACT_B_LSB +: 2];
   assign clock_select    = ctrl[CLKSEL_LSB +: 3];
   assign pfc_mode        = (waveform_select == WS_PFC_CAP) || (waveform_select == WS_PFC_CMPA);
   assign top_val         = (waveform_select == WS_PFC_CAP) ? cap_top : cmp_a;
   assign at_bottom       = (cnt == BOTTOM);
   assign at_top_turn     = !count_down && !at_bottom && (cnt >= top_val);
   assign counting_up     = !at_top_turn && !(count_down && !at_bottom);
   assign wr_fire         = aw_held && w_held && !bvalid;
   // Prescaled tick used as an enable, never as a clock
   always_comb begin
      unique case (clock_select)
         CS_DIV1:    timer_tick = 1'b1;
         CS_DIV8:    timer_tick = (presc & MASK_DIV8) == MASK_DIV8;
         CS_DIV64:   timer_tick = (presc & MASK_DIV64) == MASK_DIV64;
         CS_DIV256:  timer_tick = (presc & MASK_DIV256) == MASK_DIV256;
         CS_DIV1024: timer_tick = presc == MASK_DIV1024;
         default:    timer_tick = 1'b0;
      endcase
   end
   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_wr_addr = wr_addr;
      next_wr_data = wr_data;
      next_wr_strb = wr_strb;
      next_bvalid  = bvalid;
      next_bresp   = bresp;
      next_rvalid  = rvalid;
      next_rresp   = rresp;
      next_rdata   = rdata;
      if (S_AXI_AWVALID_I && awready) begin
         next_aw_held = 1'b1;
         next_wr_addr = S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && wready) begin
         next_w_held  = 1'b1;
         next_wr_data = S_AXI_WDATA_I;
         next_wr_strb = S_AXI_WSTRB_I;
      end
      if (bvalid && S_AXI_BREADY_I) begin
         next_bvalid = 1'b0;
      end
      if (wr_fire) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = valid_addr(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid && S_AXI_RREADY_I) begin
         next_rvalid = 1'b0;
      end
      if (S_AXI_ARVALID_I && arready) begin
         next_rvalid = 1'b1;
         next_rresp  = valid_addr(S_AXI_ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
         next_rdata  = '0;
         unique case (S_AXI_ARADDR_I)
            CTRL_OFS:    next_rdata = ctrl;
            CAP_TOP_OFS: next_rdata = 32'(cap_top);
            CMP_A_OFS:   next_rdata = 32'(cmp_a_buf);
            CMP_B_OFS:   next_rdata = 32'(cmp_b_buf);
            COUNT_OFS:   next_rdata = 32'(cnt);
            FLAGS_OFS:   next_rdata = 32'(flags) | (32'(count_down) << STS_DOWN);
            default:     next_rdata = '0;
         endcase
      end
      next_awready = !next_aw_held && !next_bvalid;
      next_wready  = !next_w_held && !next_bvalid;
      next_arready = !next_rvalid;
   end
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         awready <= 1'b0;
         wready  <= 1'b0;
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         wr_addr <= '0;
         wr_data <= '0;
         wr_strb <= '0;
         bvalid  <= 1'b0;
         bresp   <= RESP_OKAY;
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rresp   <= RESP_OKAY;
         rdata   <= '0;
      end else begin
         awready <= next_awready;
         wready  <= next_wready;
         aw_held <= next_aw_held;
         w_held  <= next_w_held;
         wr_addr <= next_wr_addr;
         wr_data <= next_wr_data;
         wr_strb <= next_wr_strb;
         bvalid  <= next_bvalid;
         bresp   <= next_bresp;
         arready <= next_arready;
         rvalid  <= next_rvalid;
         rresp   <= next_rresp;
         rdata   <= next_rdata;
      end
   end
   always_comb begin
      next_ctrl       = ctrl;
      next_cap_top    = cap_top;
      next_cmp_a_buf  = cmp_a_buf;
      next_cmp_b_buf  = cmp_b_buf;
      next_cmp_a      = cmp_a;
      next_cmp_b      = cmp_b;
      next_cnt        = cnt;
      next_count_down = count_down;
      next_flags      = flags;
      next_wave_a     = wave_a;
      next_wave_b     = wave_b;
      next_presc      = presc + 10'h001;
      if (wr_fire) begin
         unique case (wr_addr)
            CTRL_OFS:    next_ctrl = merge(ctrl, wr_data, wr_strb) & CTRL_MASK;
            CAP_TOP_OFS: next_cap_top = COUNT_W'(merge(32'(cap_top), wr_data, wr_strb));
            CMP_A_OFS:   next_cmp_a_buf = COUNT_W'(merge(32'(cmp_a_buf), wr_data, wr_strb));
            CMP_B_OFS:   next_cmp_b_buf = COUNT_W'(merge(32'(cmp_b_buf), wr_data, wr_strb));
            FLAGS_OFS:   next_flags = wr_strb[0] ? (flags & ~wr_data[FLAG_W-1:0]) : flags;
            default:     next_flags = next_flags;
         endcase
      end
      // Outside this mode compare writes take effect at once
      if (!pfc_mode) begin
         next_cmp_a = next_cmp_a_buf;
         next_cmp_b = next_cmp_b_buf;
      end
      if (timer_tick && pfc_mode) begin
         if (at_bottom) begin
            next_cmp_a = next_cmp_a_buf;
            next_cmp_b = next_cmp_b_buf;
            next_flags[FLG_WRAP] = 1'b1;
         end
         if (at_top_turn) begin
            if (waveform_select == WS_PFC_CAP) begin
               next_flags[FLG_CAP] = 1'b1;
            end else begin
               next_flags[FLG_CMP_A] = 1'b1;
            end
         end
         if (cnt == cmp_a) begin
            next_flags[FLG_CMP_A] = 1'b1;
            next_wave_a = pwm_level(output_action_a, counting_up, wave_a,
                                    waveform_select == WS_PFC_CMPA);
         end
         if (cnt == cmp_b) begin
            next_flags[FLG_CMP_B] = 1'b1;
            next_wave_b = pwm_level(output_action_b, counting_up, wave_b, 1'b0);
         end
         if (at_top_turn) begin
            next_count_down = 1'b1;
            next_cnt = cnt - ONE;
         end else if (count_down && !at_bottom) begin
            next_cnt = cnt - ONE;
         end else begin
            next_count_down = 1'b0;
            next_cnt = cnt + ONE;
         end
      end
      next_pin_a = ((output_action_a == ACT_OFF) || ((output_action_a == ACT_TOGGLE) &&
                    (waveform_select != WS_PFC_CMPA) && (waveform_select != WS_PC_CMPA)))
                   ? ctrl[LVL_A_BIT] : wave_a;
      next_pin_b = ((output_action_b == ACT_OFF) || (output_action_b == ACT_TOGGLE))
                   ? ctrl[LVL_B_BIT] : wave_b;
      next_oe_a  = ctrl[DIR_A_BIT];
      next_oe_b  = ctrl[DIR_B_BIT];
   end
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         ctrl       <= CTRL_RST;
         cap_top    <= '0;
         cmp_a_buf  <= '0;
         cmp_b_buf  <= '0;
         cmp_a      <= '0;
         cmp_b      <= '0;
         cnt        <= '0;
         count_down <= 1'b0;
         flags      <= '0;
         wave_a     <= 1'b0;
         wave_b     <= 1'b0;
         pin_a      <= 1'b0;
         pin_b      <= 1'b0;
         oe_a       <= 1'b0;
         oe_b       <= 1'b0;
         presc      <= '0;
      end else begin
         ctrl       <= next_ctrl;
         cap_top    <= next_cap_top;
         cmp_a_buf  <= next_cmp_a_buf;
         cmp_b_buf  <= next_cmp_b_buf;
         cmp_a      <= next_cmp_a;
         cmp_b      <= next_cmp_b;
         cnt        <= next_cnt;
         count_down <= next_count_down;
         flags      <= next_flags;
         wave_a     <= next_wave_a;
         wave_b     <= next_wave_b;
         pin_a      <= next_pin_a;
         pin_b      <= next_pin_b;
         oe_a       <= next_oe_a;
         oe_b       <= next_oe_b;
         presc      <= next_presc;
      end
   end
   assign S_AXI_AWREADY_O = awready;
   assign S_AXI_WREADY_O  = wready;
   assign S_AXI_BVALID_O  = bvalid;
   assign S_AXI_BRESP_O   = bresp;
   assign S_AXI_ARREADY_O = arready;
   assign S_AXI_RVALID_O  = rvalid;
   assign S_AXI_RRESP_O   = rresp;
   assign S_AXI_RDATA_O   = rdata;
   assign WAVE_A_PIN_O    = pin_a;
   assign WAVE_A_OE_O     = oe_a;
   assign WAVE_B_PIN_O    = pin_b;
   assign WAVE_B_OE_O     = oe_b;
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!ARST_N_I);
   AST_BOTTOM_STEP: assert property (timer_tick && pfc_mode && at_bottom |=> cnt == ONE && !count_down)
      else $error("counter did not leave bottom upward");
   AST_TOP_DWELL: assert property (timer_tick && pfc_mode && at_top_turn |=> count_down ##0 cnt == $past(cnt) - ONE)
      else $error("counter did not turn at top");
   AST_BOTTOM_LOAD: assert property (timer_tick && pfc_mode && at_bottom && !wr_fire
                                     |=> cmp_a == $past(cmp_a_buf) && flags[FLG_WRAP])
      else $error("buffer not loaded or wrap flag missing at bottom");
   AST_MATCH_FLAG: assert property (timer_tick && pfc_mode && cnt == cmp_b |=> flags[FLG_CMP_B])
      else $error("compare B flag missing after match");
   AST_TOP_FLAG: assert property (timer_tick && waveform_select == WS_PFC_CAP && at_top_turn |=> flags[FLG_CAP])
      else $error("capture flag missing at top");
   AST_NO_STEP: assert property (!timer_tick |=> $stable(cnt) && $stable(count_down))
      else $error("counter moved without a tick");
   AST_BUFFERED: assert property (pfc_mode && !(timer_tick && at_bottom) |=> $stable(cmp_a) && $stable(cmp_b))
      else $error("active compare changed away from bottom");
   AST_CLEAR_UP: assert property (timer_tick && pfc_mode && output_action_b == ACT_NONINV && cnt == cmp_b && counting_up
                                  |=> !wave_b ##1 !WAVE_B_PIN_O || output_action_b != ACT_NONINV)
      else $error("non-inverted output not cleared on up-count match");
   AST_DISCONNECT: assert property (output_action_a == ACT_OFF ##1 output_action_a == ACT_OFF
                                    |-> WAVE_A_PIN_O == $past(ctrl[LVL_A_BIT]))
      else $error("disconnected pin does not show port level");
   AST_DIRECTION: assert property (##1 WAVE_B_OE_O == $past(ctrl[DIR_B_BIT]))
      else $error("pin enable does not follow direction");

   COV_TURN_TOP: cover property (timer_tick && pfc_mode && at_top_turn);
   COV_WRAP: cover property (timer_tick && pfc_mode && at_bottom ##1 flags[FLG_WRAP]);
   COV_TOGGLE: cover property (waveform_select == WS_PFC_CMPA && output_action_a == ACT_TOGGLE && $changed(wave_a));
   COV_WRITE: cover property (bvalid && S_AXI_BREADY_I && bresp == RESP_OKAY);
endmodule
`default_nettype wire

// ---- pfc_pwm_pkg.sv ----
// Overview of operation
// - Dual-slope frequency correct PWM runs when waveform_select is 8 or 9.
// - Counter climbs from 0x0000 to TOP, then descends back to 0x0000.
// - Non-inverting clears output on up-count match, sets on down-count match; inverting opposite.
// - TOP is capture_top_register for 8, compare_value_a for 9; direction reverses at TOP.
// - Counter holds TOP for exactly one timer_tick before descending.
// - compare_match_flag_x sets whenever counter equals compare_value_x.
// - At BOTTOM compare buffers load and count_wrap_flag sets in the same tick.
// - At TOP the compare A flag or capture_flag sets, per TOP source.
// - output_action_x two gives non-inverted PWM, three gives inverted PWM.
// - Waveform reaches the pin only while pin_direction_x selects output.
// - Compare at BOTTOM gives steady low, at TOP steady high, non-inverted.
// - Mode 9 with output_action_a one toggles waveform_out_a per match.
// - timer_tick is the clock divided by 1, 8, 64, 256 or 1024.
// - Fully synchronous; timer_tick is a clock enable, not a clock.
// - Action one toggles only in modes 9 or 11, else disconnected; code toggles A in mode 9 only, B stays disconnected.
// - Action zero disconnects the waveform; pin keeps normal port level.
package pfc_pwm_pkg;
   localparam int unsigned ADDR_W      = 8;
   localparam logic [7:0]  CTRL_OFS    = 8'h00;
   localparam logic [7:0]  CAP_TOP_OFS = 8'h04;
   localparam logic [7:0]  CMP_A_OFS   = 8'h08;
   localparam logic [7:0]  CMP_B_OFS   = 8'h0C;
   localparam logic [7:0]  COUNT_OFS   = 8'h10;
   localparam logic [7:0]  FLAGS_OFS   = 8'h14;
   localparam int unsigned WS_LSB      = 0;
   localparam int unsigned ACT_A_LSB   = 4;
   localparam int unsigned ACT_B_LSB   = 6;
   localparam int unsigned CLKSEL_LSB  = 8;
   localparam int unsigned DIR_A_BIT   = 12;
   localparam int unsigned DIR_B_BIT   = 13;
   localparam int unsigned LVL_A_BIT   = 16;
   localparam int unsigned LVL_B_BIT   = 17;
   localparam logic [31:0] CTRL_MASK   = 32'h0003_37FF;
   localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
   localparam int unsigned FLAG_W      = 4;
   localparam int unsigned FLG_WRAP    = 0;
   localparam int unsigned FLG_CMP_A   = 1;
   localparam int unsigned FLG_CMP_B   = 2;
   localparam int unsigned FLG_CAP     = 3;
   localparam int unsigned STS_DOWN    = 8;
   localparam logic [3:0]  WS_PFC_CAP  = 4'h8;
   localparam logic [3:0]  WS_PFC_CMPA = 4'h9;
   localparam logic [3:0]  WS_PC_CMPA  = 4'hB;
   localparam logic [1:0]  ACT_OFF     = 2'h0;
   localparam logic [1:0]  ACT_TOGGLE  = 2'h1;
   localparam logic [1:0]  ACT_NONINV  = 2'h2;
   localparam logic [1:0]  ACT_INV     = 2'h3;
   localparam logic [2:0]  CS_DIV1     = 3'h1;
   localparam logic [2:0]  CS_DIV8     = 3'h2;
   localparam logic [2:0]  CS_DIV64    = 3'h3;
   localparam logic [2:0]  CS_DIV256   = 3'h4;
   localparam logic [2:0]  CS_DIV1024  = 3'h5;
   localparam logic [9:0]  MASK_DIV8   = 10'h007;
   localparam logic [9:0]  MASK_DIV64  = 10'h03F;
   localparam logic [9:0]  MASK_DIV256 = 10'h0FF;
   localparam logic [9:0]  MASK_DIV1024 = 10'h3FF;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import pfc_pwm_pkg::*;
   logic             clk     = 1'b0;
   logic             arst_n  = 1'b0;
   logic [7:0]       awaddr  = 8'h00;
   logic [7:0]       araddr  = 8'h00;
   logic             awvalid = 1'b0;
   logic             wvalid  = 1'b0;
   logic             bready  = 1'b0;
   logic             arvalid = 1'b0;
   logic             rready  = 1'b0;
   logic [31:0]      wdata   = 32'h0000_0000;
   logic [3:0]       wstrb   = 4'h0;
   wire logic        awready;
   wire logic        wready;
   wire logic        bvalid;
   wire logic        arready;
   wire logic        rvalid;
   wire logic        pin_a;
   wire logic        oe_a;
   wire logic        pin_b;
   wire logic        oe_b;
   wire logic [1:0]  bresp;
   wire logic [1:0]  rresp;
   wire logic [31:0] rdata;
   int               fail_count = 0;
   int               n_compared = 0;
   int               cyc        = 0;
   logic [31:0]      rd0;
   logic [31:0]      rd1;

   pfc_pwm #(.COUNT_W(16)) uut (
      .CORE_CLK_I(clk), .ARST_N_I(arst_n),
      .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
      .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
      .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
      .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
      .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
      .WAVE_A_PIN_O(pin_a), .WAVE_A_OE_O(oe_a), .WAVE_B_PIN_O(pin_b), .WAVE_B_OE_O(oe_b)
   );

   always #2 clk = ~clk;

   // Hang guard: the whole sequence needs about 35000 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fail_count++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   function automatic logic [31:0] ctrl(input logic [3:0] ws, input logic [1:0] aa, input logic [1:0] ab,
                                        input logic [2:0] cs, input logic da, input logic db,
                                        input logic la, input logic lb);
      return {14'h0000, lb, la, 2'h0, db, da, 1'b0, cs, ab, aa, ws};
   endfunction

   // Entered just after a rising edge; returns one edge after the response edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, bresp});
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      d = rdata;
      chk("rresp", {30'h0, er}, {30'h0, rresp});
      @(posedge clk);
   endtask

   task automatic count_high(input string name, input logic use_b, input int n, input int exp);
      int h;
      h = 0;
      repeat (n) begin
         @(negedge clk);
         h += (use_b ? pin_b : pin_a) ? 1 : 0;
      end
      chk(name, exp, h);
      @(posedge clk);
   endtask

   task automatic t_regs();
      rd(CTRL_OFS, RESP_OKAY, rd0);
      chk("ctrl reset", CTRL_RST, rd0);
      rd(8'h18, RESP_SLVERR, rd0);
      wr(8'h18, 32'hFFFF_FFFF, RESP_SLVERR);
      wr(CTRL_OFS, 32'hFFFF_FFFF, RESP_OKAY);
      rd(CTRL_OFS, RESP_OKAY, rd0);
      chk("ctrl mask", CTRL_MASK, rd0);
      wr(CTRL_OFS, 32'h0000_0000, RESP_OKAY);
   endtask

   // Channel B over two full periods: high time is 2*cmp ticks per period, 2*(top-cmp) when inverted
   task automatic t_pwm(input logic [3:0] ws, input int top, input int cmp, input logic inv,
                        input logic [2:0] cs, input int div);
      wr(CAP_TOP_OFS, top, RESP_OKAY);
      wr(CMP_A_OFS, top, RESP_OKAY);
      wr(CMP_B_OFS, cmp, RESP_OKAY);
      wr(CTRL_OFS, ctrl(ws, ACT_OFF, inv ? ACT_INV : ACT_NONINV, cs, 1'b0, 1'b1, 1'b0, 1'b0), RESP_OKAY);
      repeat (4 * top * div) @(posedge clk);
      chk("oe_b", 32'h1, {31'h0, oe_b});
      count_high("pin_b", 1'b1, 4 * top * div, inv ? 4 * (top - cmp) * div : 4 * cmp * div);
   endtask

   task automatic t_toggle();
      wr(CMP_A_OFS, 5, RESP_OKAY);
      wr(CTRL_OFS, ctrl(WS_PFC_CMPA, ACT_TOGGLE, ACT_OFF, CS_DIV1, 1'b1, 1'b0, 1'b0, 1'b1), RESP_OKAY);
      repeat (30) @(posedge clk);
      count_high("toggle a", 1'b0, 20, 10);
      chk("oe_b off", 32'h0, {31'h0, oe_b});
      chk("oe_a on", 32'h1, {31'h0, oe_a});
      count_high("port b", 1'b1, 20, 20);
      wr(CTRL_OFS, ctrl(WS_PFC_CAP, ACT_TOGGLE, ACT_OFF, CS_DIV1, 1'b1, 1'b0, 1'b1, 1'b0), RESP_OKAY);
      repeat (4) @(posedge clk);
      count_high("toggle off a", 1'b0, 20, 20);
   endtask

   task automatic t_flags();
      wr(CTRL_OFS, ctrl(WS_PFC_CAP, ACT_OFF, ACT_NONINV, CS_DIV1, 1'b0, 1'b1, 1'b0, 1'b0), RESP_OKAY);
      wr(FLAGS_OFS, 32'h0000_000F, RESP_OKAY);
      repeat (30) @(posedge clk);
      rd(FLAGS_OFS, RESP_OKAY, rd0);
      chk("flags run", 32'hF, rd0 & 32'hF);
      wr(CTRL_OFS, ctrl(WS_PFC_CAP, ACT_OFF, ACT_NONINV, 3'h0, 1'b0, 1'b1, 1'b0, 1'b0), RESP_OKAY);
      wr(FLAGS_OFS, 32'h0000_000F, RESP_OKAY);
      rd(COUNT_OFS, RESP_OKAY, rd0);
      repeat (20) @(posedge clk);
      rd(COUNT_OFS, RESP_OKAY, rd1);
      chk("count stopped", rd0, rd1);
      rd(FLAGS_OFS, RESP_OKAY, rd1);
      chk("flags stopped", 32'h0, rd1 & 32'hF);
   endtask

   initial begin
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      t_regs();
      t_pwm(WS_PFC_CMPA, 5, 2, 1'b0, CS_DIV1, 1);
      t_pwm(WS_PFC_CAP, 5, 2, 1'b1, CS_DIV1, 1);
      t_pwm(WS_PFC_CAP, 5, 0, 1'b0, CS_DIV1, 1);
      t_pwm(WS_PFC_CAP, 5, 5, 1'b0, CS_DIV1, 1);
      t_pwm(WS_PFC_CAP, 6, 2, 1'b0, CS_DIV8, 8);
      t_pwm(WS_PFC_CMPA, 4, 3, 1'b1, CS_DIV64, 64);
      t_pwm(WS_PFC_CAP, 3, 1, 1'b0, CS_DIV256, 256);
      t_pwm(WS_PFC_CAP, 3, 2, 1'b1, CS_DIV1024, 1024);
      t_flags();
      t_pwm(WS_PFC_CAP, 4, 1, 1'b0, CS_DIV1, 1);
      t_toggle();
      stop_test();
   end
endmodule
`default_nettype wire
